// [bench/hscl_pulse_src.sv]
// External pulse source that drives the counter's count input
`timescale 1ns/1ps
module hscl_pulse_src
(
  input wire logic clock,
  output logic pin
);
  // Idle low between bursts
  initial pin = 1'b0;
  // ---------------------------------------------------------------
  // Pulse bursts
  // ---------------------------------------------------------------
  // Pulses stay high for two edges so the input synchroniser sees each one
  task automatic send(input int n, input int gap);
    repeat (n)
    begin
      @(posedge clock) pin <= 1'b1;
      repeat (2) @(posedge clock);
      pin <= 1'b0;
      repeat (gap) @(posedge clock);
    end
    // Cover the synchroniser latency before anyone looks at the count
    repeat (5) @(posedge clock);
  endtask
endmodule // hscl_pulse_src

// [bench/testbench.sv]
// Self-checking bench for the counter channel
`timescale 1ns/1ps
`include "hscl_params.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import hscl_pkg::*;
  logic clock;
  logic rst_n;
  hscl_req_type bus_req;
  hscl_rsp_type bus_rsp;
  logic count_pin;
  logic irq;
  logic error;
  logic [31:0] count_out;
  logic [31:0] rd;
  logic [31:0] lo;
  logic [31:0] up;
  logic [6:0] ctl;
  int err_count;
  int n_tests;
  int i;
  int per[5] = '{0, 62, 250, 2500, 25000};
  hscl_counter dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .count_pin(count_pin), .irq(irq), .error(error), .count_out(count_out));
  hscl_pulse_src src (.clock(clock), .pin(count_pin));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // One bus access held until waitrequest is seen low; read data taken at that edge
  task automatic acc(input logic rnw, input logic [3:0] a, input logic [31:0] d);
    bus_req <= '{address: a, read: rnw, write: !rnw, writedata: d};
    @(posedge clock);
    while (bus_rsp.waitrequest !== 1'b0)
      @(posedge clock);
    rd = bus_rsp.readdata;
    bus_req <= '0;
    @(posedge clock);
  endtask
  // Expected count after one step, judged against the current bounds
  function automatic logic [31:0] nxt(input logic [31:0] v, input logic [6:0] c);
    if (c[2])
    begin
      if (c[0] && $signed(v) <= $signed(lo)) return up;
      if (c[1] && $signed(v) <= $signed(lo)) return lo;
      return v - 32'h1;
    end
    if (c[0] && $signed(v) >= $signed(up)) return lo;
    if (c[1] && $signed(v) >= $signed(up)) return up;
    return v + 32'h1;
  endfunction
  // Configure while stopped, then run n pin pulses
  task automatic run(input logic [31:0] s, input logic [6:0] c, input int n);
    logic [31:0] e;
    e = s;
    acc(1'b0, `HSCL_OFF_CTRL, 32'h0);
    acc(1'b0, `HSCL_OFF_UPPER, up);
    acc(1'b0, `HSCL_OFF_LOWER, lo);
    acc(1'b0, `HSCL_OFF_COUNT, s);
    acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
    acc(1'b0, `HSCL_OFF_CTRL, {25'h0, c} | 32'h40);
    src.send(n, $urandom_range(2, 8));
    repeat (n) e = nxt(e, c);
    `CHK("count", e, count_out)
  endtask
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Timebase sweep dominates; this leaves ample margin over it
  initial
  begin
    repeat (80000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(80420));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    acc(1'b1, `HSCL_OFF_UPPER, 32'h0);
    `CHK("upper", `HSCL_UPPER_RST, rd)
    acc(1'b1, `HSCL_OFF_LOWER, 32'h0);
    `CHK("lower", `HSCL_LOWER_RST, rd)
    `CHK("count0", 32'h0, count_out)
    // Overflow hold, flag, irq masking and the three ways to drop the flag
    up = $urandom_range(100, 1000);
    lo = 32'h0 - up;
    for (i = 0; i < 3; i++)
    begin
      acc(1'b0, `HSCL_OFF_MASK, (i == 1) ? 32'h0 : 32'h7);
      run(up - 32'h2, 7'h02, 4);
      `CHK("error", 1'b1, error)
      `CHK("irq", (i != 1), irq)
      acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
      `CHK("status", 5'h19, rd[4:0])
      acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
      `CHK("sticky", 5'h18, rd[4:0])
      `CHK("irqoff", 1'b0, irq)
      acc(1'b0, `HSCL_OFF_CMD, 32'h1 << (i + (i > 0)));
      acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
      `CHK("flag", 5'h10, rd[4:0])
      acc(1'b0, `HSCL_OFF_STATUS, 32'h10);
      `CHK("errclr", 1'b0, error)
    end
    // Underflow hold
    run(lo + 32'h1, 7'h06, 3);
    acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
    `CHK("unf", 3'h2, rd[2:0])
    `CHK("unfflag", 1'b1, rd[5])
    acc(1'b0, `HSCL_OFF_CMD, 32'h2);
    acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
    `CHK("unfclr", 1'b0, rd[5])
    acc(1'b0, `HSCL_OFF_STATUS, 32'h10);
    // Ring with checking asked for: wraps, yet no error flags
    lo = $urandom_range(0, 2000000) - 1000000;
    up = lo + $urandom_range(3, 40);
    run(up, 7'h03, 2);
    acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
    `CHK("ringup", 3'h4, rd[2:0])
    run(lo, 7'h07, 2);
    acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
    `CHK("ringdn", 3'h4, rd[2:0])
    // No checking: bounds ignored, full signed range wraps
    run(32'h7fffffff, 7'h00, 2);
    run(32'h80000000, 7'h04, 1);
    // Random modes near freshly changed bounds
    for (i = 0; i < 8; i++)
    begin
      lo = $urandom_range(0, 2000000) - 1000000;
      up = lo + $urandom_range(3, 40);
      ctl = {4'h0, 3'($urandom_range(0, 7))};
      run(($urandom_range(0, 1) != 0) ? up - 32'h1 : lo + 32'h1, ctl, $urandom_range(1, 5));
      acc(1'b1, `HSCL_OFF_STATUS, 32'h0);
      if (ctl[0])
        `CHK("ringflags", 2'h0, rd[1:0])
      acc(1'b0, `HSCL_OFF_STATUS, 32'h10);
    end
    // Every internal timebase: one and a half periods give one or two ticks
    for (i = 1; i < 5; i++)
    begin
      acc(1'b0, `HSCL_OFF_CTRL, 32'h0);
      acc(1'b0, `HSCL_OFF_CMD, 32'h4);
      acc(1'b0, `HSCL_OFF_CTRL, 32'h40 | (i << 3));
      repeat (per[i] * 3 / 2) @(posedge clock);
      `CHK("ticks", 1'b1, (count_out inside {32'h1, 32'h2}))
    end
    report_and_stop();
  end
endmodule // testbench

// [design/hscl_counter.sv]
// One 32-bit counter channel with linear/ring limits and error flags
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "hscl_params.svh"
module hscl_counter
  import hscl_pkg::*;
#(
  parameter int CLK_MHZ = `HSCL_CLK_MHZ
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire hscl_pkg::hscl_req_type bus_req,
  output hscl_pkg::hscl_rsp_type bus_rsp,
  input wire logic count_pin,
  output logic irq,
  output logic error,
  output logic [31:0] count_out
);
  import hscl_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [6:0] ctrl_r;
  logic [31:0] upper_r;
  logic [31:0] lower_r;
  logic [31:0] preset_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic ovf_r;
  logic unf_r;
  logic error_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [31:0] rdata_r;
  logic rd_done_r;
  logic rd_take;
  logic err_clr;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  logic tb_tick;
  logic step;
  logic ovf_ev;
  logic unf_ev;
  logic wrap_ev;
  logic ring;
  logic limen;
  logic wr;
  logic rd;
  logic cmd_ovf_clr;
  logic cmd_unf_clr;
  logic cmd_rst;
  logic cmd_pre;
  logic status_rd;
  hscl_src_type src;

  // Decode of a register offset against the request
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // ------------------------------------------------------------
  // Bus slave: writes at once, reads after one wait state
  // ------------------------------------------------------------
  assign wr = bus_req.write;
  assign rd = bus_req.read;
  // Capture cycle of a read; the wait state lets registered data stand at the answer
  assign rd_take = rd && !rd_done_r;
  assign bus_rsp.waitrequest = rd_take;
  assign bus_rsp.readdata = rdata_r;
  assign cmd_ovf_clr = wr && hit(bus_req.address, `HSCL_OFF_CMD)
                       && bus_req.writedata[`HSCL_CMD_OVF_CLR];
  assign cmd_unf_clr = wr && hit(bus_req.address, `HSCL_OFF_CMD)
                       && bus_req.writedata[`HSCL_CMD_UNF_CLR];
  assign cmd_rst = wr && hit(bus_req.address, `HSCL_OFF_CMD)
                   && bus_req.writedata[`HSCL_CMD_RESET];
  assign cmd_pre = wr && hit(bus_req.address, `HSCL_OFF_CMD)
                   && bus_req.writedata[`HSCL_CMD_PRESET];
  // Clear only on the capture edge so an event during the wait state is kept
  assign status_rd = rd_take && hit(bus_req.address, `HSCL_OFF_STATUS);
  assign err_clr = wr && hit(bus_req.address, `HSCL_OFF_STATUS)
                   && bus_req.writedata[`HSCL_ST_ERR];

  // Marks the cycle in which captured read data stand on the bus
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rd_done_r <= 1'b0;
    else
      rd_done_r <= rd_take;
  end

  // Read data registered so they stand at the next edge; zero when unmapped
  always_comb
  begin
    count_out = count_r;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (rd_take)
    begin
      unique case (bus_req.address)
        `HSCL_OFF_CTRL: rdata_r <= {25'h0, ctrl_r};
        `HSCL_OFF_UPPER: rdata_r <= upper_r;
        `HSCL_OFF_LOWER: rdata_r <= lower_r;
        `HSCL_OFF_COUNT: rdata_r <= count_r;
        `HSCL_OFF_PRESET: rdata_r <= preset_r;
        `HSCL_OFF_STATUS: rdata_r <= {26'h0, unf_r, error_r, ovf_r, status_r};
        `HSCL_OFF_MASK: rdata_r <= {29'h0, mask_r};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  // Configuration writes; bounds act immediately on the next step
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `HSCL_CTRL_RST;
      upper_r <= `HSCL_UPPER_RST;
      lower_r <= `HSCL_LOWER_RST;
      preset_r <= 32'h0;
      mask_r <= 3'h0;
    end
    else if (wr)
    begin
      if (hit(bus_req.address, `HSCL_OFF_CTRL))
        ctrl_r <= bus_req.writedata[6:0];
      if (hit(bus_req.address, `HSCL_OFF_UPPER))
        upper_r <= bus_req.writedata;
      if (hit(bus_req.address, `HSCL_OFF_LOWER))
        lower_r <= bus_req.writedata;
      if (hit(bus_req.address, `HSCL_OFF_PRESET))
        preset_r <= bus_req.writedata;
      if (hit(bus_req.address, `HSCL_OFF_MASK))
        mask_r <= bus_req.writedata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Count source
  // ------------------------------------------------------------
  assign ring = ctrl_r[`HSCL_CTRL_RING];
  // Limit checking has no effect in ring mode
  assign limen = ctrl_r[`HSCL_CTRL_LIMEN] && !ring;
  assign src = hscl_src_type'(ctrl_r[`HSCL_CTRL_SRC_HI:`HSCL_CTRL_SRC_LO]);

  hscl_timebase #(
    .CLK_MHZ(CLK_MHZ)
  ) u_tb (
    .clock(clock),
    .rst_n(rst_n),
    .sel(src),
    .tick(tb_tick)
  );

  // Pin synchroniser then rising-edge detect on the second stage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= count_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // One step per pin edge or timebase tick, only while running
  assign step = ctrl_r[`HSCL_CTRL_RUN]
                && ((src == HSCL_SRC_PIN) ? (pin_s2_r && !pin_d_r) : tb_tick);

  // ------------------------------------------------------------
  // Next count with hold, wrap or free run
  // ------------------------------------------------------------
  always_comb
  begin
    count_nxt = count_r;
    ovf_ev = 1'b0;
    unf_ev = 1'b0;
    wrap_ev = 1'b0;
    if (step)
    begin
      if (!ctrl_r[`HSCL_CTRL_DOWN])
      begin
        if (ring && $signed(count_r) >= $signed(upper_r))
        begin
          count_nxt = lower_r;
          wrap_ev = 1'b1;
        end
        else if (limen && $signed(count_r) >= $signed(upper_r))
        begin
          count_nxt = upper_r;
          ovf_ev = 1'b1;
        end
        else
          count_nxt = count_r + 32'h1;
      end
      else
      begin
        if (ring && $signed(count_r) <= $signed(lower_r))
        begin
          count_nxt = upper_r;
          wrap_ev = 1'b1;
        end
        else if (limen && $signed(count_r) <= $signed(lower_r))
        begin
          count_nxt = lower_r;
          unf_ev = 1'b1;
        end
        else
          count_nxt = count_r - 32'h1;
      end
    end
  end

  // Counter register; software reset and preset win over a step
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= 32'h0;
    else if (cmd_rst)
      count_r <= 32'h0;
    else if (cmd_pre)
      count_r <= preset_r;
    else if (wr && hit(bus_req.address, `HSCL_OFF_COUNT))
      count_r <= bus_req.writedata;
    else
      count_r <= count_nxt;
  end

  // ------------------------------------------------------------
  // Error flags: an event in the clearing cycle still sets
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end
    else
    begin
      if (ovf_ev)
        ovf_r <= 1'b1;
      else if (cmd_ovf_clr || cmd_rst || cmd_pre)
        ovf_r <= 1'b0;
      if (unf_ev)
        unf_r <= 1'b1;
      else if (cmd_unf_clr || cmd_rst || cmd_pre)
        unf_r <= 1'b0;
    end
  end

  // Error latch needs its own clear so flags alone do not drop it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      error_r <= 1'b0;
    else if (ovf_ev || unf_ev)
      error_r <= 1'b1;
    else if (err_clr)
      error_r <= 1'b0;
  end
  assign error = error_r;

  // Sticky interrupt status, cleared by reading it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= 3'h0;
    else
      status_r <= (status_rd ? 3'h0 : status_r) | {wrap_ev, unf_ev, ovf_ev};
  end
  assign irq = |(status_r & mask_r);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_hold_up;
    @(posedge clock) disable iff (!rst_n)
    (ovf_ev && !cmd_rst && !cmd_pre && !wr) |=> (count_r == $past(upper_r));
  endproperty
  a_hold_up: assert property (p_hold_up) else $error("no hold at upper");
  property p_hold_dn;
    @(posedge clock) disable iff (!rst_n)
    (unf_ev && !wr) |=> (count_r == $past(lower_r));
  endproperty
  a_hold_dn: assert property (p_hold_dn) else $error("no hold at lower");
  property p_wrap_up;
    @(posedge clock) disable iff (!rst_n)
    (wrap_ev && !ctrl_r[`HSCL_CTRL_DOWN] && !wr) |=> (count_r == $past(lower_r));
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("no wrap to lower");
  property p_wrap_dn;
    @(posedge clock) disable iff (!rst_n)
    (wrap_ev && ctrl_r[`HSCL_CTRL_DOWN] && !wr) |=> (count_r == $past(upper_r));
  endproperty
  a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap to upper");
  property p_ring_noflag;
    @(posedge clock) disable iff (!rst_n)
    ring |-> !(ovf_ev || unf_ev);
  endproperty
  a_ring_noflag: assert property (p_ring_noflag) else $error("flag in ring");
  property p_free;
    @(posedge clock) disable iff (!rst_n)
    (step && !ring && !limen && !ctrl_r[`HSCL_CTRL_DOWN] && !wr)
      |=> (count_r == $past(count_r) + 32'h1);
  endproperty
  a_free: assert property (p_free) else $error("free count wrong");
  sequence s_ovf;
    ovf_ev ##1 ovf_r;
  endsequence
  property p_flag;
    @(posedge clock) disable iff (!rst_n)
    ovf_ev |-> s_ovf ##0 error_r;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_clr;
    @(posedge clock) disable iff (!rst_n)
    (cmd_ovf_clr && !ovf_ev) |=> !ovf_r;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_clr_unf;
    @(posedge clock) disable iff (!rst_n)
    (cmd_unf_clr && !unf_ev) |=> !unf_r;
  endproperty
  a_clr_unf: assert property (p_clr_unf) else $error("underflow flag not cleared");
  property p_err_keep;
    @(posedge clock) disable iff (!rst_n)
    (error_r && !err_clr) |=> error_r;
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("error dropped without clear");
endmodule // hscl_counter

// [design/hscl_timebase.sv]
// Internal timebase: one-cycle tick at a selectable period
`timescale 1ns/1ps
`include "hscl_params.svh"
module hscl_timebase
  import hscl_pkg::*;
#(
  parameter int CLK_MHZ = `HSCL_CLK_MHZ
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire hscl_pkg::hscl_src_type sel,
  output logic tick
);
  // ------------------------------------------------------------
  // Period counts derived from the clock rate
  // ------------------------------------------------------------
  localparam int C0 = (`HSCL_TB0_NS * CLK_MHZ) / 1000;
  localparam int C1 = (`HSCL_TB1_NS * CLK_MHZ) / 1000;
  localparam int C2 = (`HSCL_TB2_NS * CLK_MHZ) / 1000;
  localparam int C3 = (`HSCL_TB3_NS * CLK_MHZ) / 1000;
  // Refuse a clock too slow to form the shortest period
  if (C0 < 1)
  begin : g_rate_check
    $error("clock too slow for the fastest timebase");
  end
  logic [31:0] cnt_r;
  logic [31:0] limit;
  // Terminal count picked from the selection
  always_comb
  begin
    unique case (sel)
      HSCL_SRC_T025: limit = 32'(C0 - 1);
      HSCL_SRC_T1: limit = 32'(C1 - 1);
      HSCL_SRC_T10: limit = 32'(C2 - 1);
      HSCL_SRC_T100: limit = 32'(C3 - 1);
      default: limit = 32'h0;
    endcase
  end
  // Free divider; restarts when the pin source is chosen
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 32'h0;
    else if (sel == HSCL_SRC_PIN || cnt_r >= limit)
      cnt_r <= 32'h0;
    else
      cnt_r <= cnt_r + 32'h1;
  end
  // Illegal source codes give no ticks rather than one every cycle
  assign tick = (sel inside {HSCL_SRC_T025, HSCL_SRC_T1, HSCL_SRC_T10, HSCL_SRC_T100})
                && (cnt_r >= limit);
endmodule // hscl_timebase

// [inc/hscl_params.svh]
// Offsets, field positions, reset values and timing figures of the counter channel
`ifndef HSCL_PARAMS_SVH
`define HSCL_PARAMS_SVH
`define HSCL_OFF_CTRL 4'h0
`define HSCL_OFF_UPPER 4'h1
`define HSCL_OFF_LOWER 4'h2
`define HSCL_OFF_COUNT 4'h3
`define HSCL_OFF_PRESET 4'h4
`define HSCL_OFF_STATUS 4'h5
`define HSCL_OFF_MASK 4'h6
`define HSCL_OFF_CMD 4'h7
`define HSCL_CTRL_RING 0
`define HSCL_CTRL_LIMEN 1
`define HSCL_CTRL_DOWN 2
`define HSCL_CTRL_SRC_LO 3
`define HSCL_CTRL_SRC_HI 5
`define HSCL_CTRL_RUN 6
`define HSCL_CMD_OVF_CLR 0
`define HSCL_CMD_UNF_CLR 1
`define HSCL_CMD_RESET 2
`define HSCL_CMD_PRESET 3
`define HSCL_ST_OVF 0
`define HSCL_ST_UNF 1
`define HSCL_ST_WRAP 2
`define HSCL_ST_ERR 4
`define HSCL_UPPER_RST 32'h7fffffff
`define HSCL_LOWER_RST 32'h80000000
`define HSCL_CTRL_RST 7'h00
`define HSCL_CLK_MHZ 250
`define HSCL_TB0_NS 250
`define HSCL_TB1_NS 1000
`define HSCL_TB2_NS 10000
`define HSCL_TB3_NS 100000
`endif

// [inc/hscl_pkg.sv]
// Types shared by the counter channel files
package hscl_pkg;
  typedef enum logic [2:0]
  {
    HSCL_SRC_PIN = 3'h0,
    HSCL_SRC_T025 = 3'h1,
    HSCL_SRC_T1 = 3'h2,
    HSCL_SRC_T10 = 3'h3,
    HSCL_SRC_T100 = 3'h4
  } hscl_src_type;
  typedef struct packed
  {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } hscl_req_type;
  typedef struct packed
  {
    logic [31:0] readdata;
    logic waitrequest;
  } hscl_rsp_type;
endpackage
